// ==== core/aocrs_regs.svh ====
// constants of the output coding and range select block
`ifndef AOCRS_REGS_SVH
`define AOCRS_REGS_SVH

// result width, also the default of the width parameter
`define AOCRS_CODE_W 16
// synchroniser depth for pins
`define AOCRS_SYNC_STAGES 2
// number of pins passing the synchroniser
`define AOCRS_PIN_COUNT 5
// bit positions of the pins inside the synchronised bundle
`define AOCRS_PIN_CODING 0
`define AOCRS_PIN_BIPOLAR 1
`define AOCRS_PIN_SPAN 2
`define AOCRS_PIN_REFPD 3
`define AOCRS_PIN_BUFPD 4
// reset values
`define AOCRS_RST_CODING 1'b0
`define AOCRS_RST_VALID 1'b0
`define AOCRS_RST_REFEN 1'b0
`define AOCRS_RST_RANGE AOCRS_RNG_U5

`endif

// ==== core/aocrs_pkg.sv ====
// types of the output coding and range select block
package aocrs_pkg;

    typedef enum logic [1:0] {
        AOCRS_RNG_U5,
        AOCRS_RNG_U10,
        AOCRS_RNG_B5,
        AOCRS_RNG_B10
    } aocrs_range_e;

    typedef enum logic {
        AOCRS_COD_BINARY,
        AOCRS_COD_TWOS
    } aocrs_coding_e;

endpackage

// ==== core/aocrs_sync.sv ====
// two flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
module aocrs_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // pins in, synchronised levels out
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_sync_ff
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_pin_sync;

    initial begin
        if (WIDTH < 1) begin
            $error("aocrs_sync: WIDTH must be at least 1");
        end
    end

    // first stage feeds only the second stage
    always_comb begin
        nxt_meta = pin_async;
        nxt_pin_sync = meta_ff;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= '0;
            pin_sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            pin_sync_ff <= nxt_pin_sync;
        end
    end

endmodule

// ==== core/aocrs_top.sv ====
// result coding, saturation and range/reference decode of the converter
`timescale 1ns/1ps
`include "aocrs_regs.svh"
// Notes on behaviour
// - a result is in straight binary or twos complement, by pin or register.
// - under the register the coding pin is ignored; the host holds it fixed.
// - -FS, mid, +FS-1: binary 0x0000/0x8000/0xFFFF, twos 0x8000/0x0000/0x7FFF.
// - above the span gives the top code, below it the bottom code; no wrap.
// - in pin modes the bipolar and span pins give 5 V, 10 V, +-5 V, +-10 V.
// - under the register the bipolar and span pins are ignored and tied.
// - both power-downs low enable band-gap, buffer and temperature sensor.
// - a new range or coding applies after one acquisition, no reset needed.
module aocrs_top
    import aocrs_pkg::*;
#(
    parameter int CODE_W = `AOCRS_CODE_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // device pins, asynchronous
    input wire logic output_coding_select,
    input wire logic bipolar_select,
    input wire logic span_double_select,
    input wire logic ref_powerdown,
    input wire logic refbuffer_powerdown,
    // configuration register contents, same clock
    input wire logic cfg_reg_active,
    input wire logic cfg_coding_twos,
    input wire logic cfg_bipolar,
    input wire logic cfg_span_double,
    // converter core
    input wire logic acq_done,
    input wire logic raw_valid,
    input wire logic [CODE_W-1:0] raw_code,
    input wire logic raw_over,
    input wire logic raw_under,
    // formatted result
    output logic [CODE_W-1:0] result_ff,
    output logic result_valid_ff,
    // applied configuration
    output aocrs_coding_e coding_ff,
    output aocrs_range_e range_ff,
    // reference control
    output logic intref_en_ff,
    output logic refbuf_en_ff,
    output logic tempsense_en_ff
);

    localparam int MSB = CODE_W - 1;

    logic [`AOCRS_PIN_COUNT-1:0] pins_async;
    logic [`AOCRS_PIN_COUNT-1:0] pins_s;
    logic coding_s;
    logic bipolar_s;
    logic span_s;
    logic refpd_s;
    logic bufpd_s;

    aocrs_coding_e nxt_coding;
    aocrs_range_e nxt_range;
    logic [CODE_W-1:0] nxt_result;
    logic nxt_result_valid;
    logic [CODE_W-1:0] sat_bin;
    logic nxt_intref_en;
    logic nxt_refbuf_en;
    logic nxt_tempsense_en;

    initial begin
        if (CODE_W < 2) begin
            $error("aocrs_top: CODE_W must be at least 2");
        end
    end

    function automatic aocrs_range_e decode_range(input logic bip,
                                                  input logic dbl);
        aocrs_range_e r;
        r = AOCRS_RNG_U5;
        if (bip && dbl) begin
            r = AOCRS_RNG_B10;
        end else if (bip) begin
            r = AOCRS_RNG_B5;
        end else if (dbl) begin
            r = AOCRS_RNG_U10;
        end
        return r;
    endfunction

    assign pins_async = {refbuffer_powerdown, ref_powerdown,
                         span_double_select, bipolar_select,
                         output_coding_select};

    aocrs_sync #(
        .WIDTH(`AOCRS_PIN_COUNT)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_async(pins_async),
        .pin_sync_ff(pins_s)
    );

    assign coding_s = pins_s[`AOCRS_PIN_CODING];
    assign bipolar_s = pins_s[`AOCRS_PIN_BIPOLAR];
    assign span_s = pins_s[`AOCRS_PIN_SPAN];
    assign refpd_s = pins_s[`AOCRS_PIN_REFPD];
    assign bufpd_s = pins_s[`AOCRS_PIN_BUFPD];

    // configuration is taken only at the end of an acquisition so that
    // a conversion in flight never sees a half applied change
    always_comb begin
        nxt_coding = coding_ff;
        nxt_range = range_ff;
        if (acq_done) begin
            if (cfg_reg_active) begin
                nxt_coding = cfg_coding_twos ? AOCRS_COD_TWOS :
                             AOCRS_COD_BINARY;
                nxt_range = decode_range(cfg_bipolar, cfg_span_double);
            end else begin
                nxt_coding = coding_s ? AOCRS_COD_BINARY :
                             AOCRS_COD_TWOS;
                nxt_range = decode_range(bipolar_s, span_s);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            coding_ff <= aocrs_coding_e'(`AOCRS_RST_CODING);
            range_ff <= `AOCRS_RST_RANGE;
        end else begin
            coding_ff <= nxt_coding;
            range_ff <= nxt_range;
        end
    end

    // saturate in straight binary first, then recode the top bit
    always_comb begin
        sat_bin = raw_code;
        if (raw_over) begin
            sat_bin = '1;
        end else if (raw_under) begin
            sat_bin = '0;
        end
        nxt_result = result_ff;
        nxt_result_valid = raw_valid;
        if (raw_valid) begin
            if (coding_ff == AOCRS_COD_TWOS) begin
                nxt_result = {~sat_bin[MSB], sat_bin[MSB-1:0]};
            end else begin
                nxt_result = sat_bin;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            result_ff <= '0;
            result_valid_ff <= `AOCRS_RST_VALID;
        end else begin
            result_ff <= nxt_result;
            result_valid_ff <= nxt_result_valid;
        end
    end

    // reference follows the pins directly, no acquisition gating
    always_comb begin
        nxt_intref_en = !refpd_s && !bufpd_s;
        nxt_refbuf_en = !bufpd_s;
        nxt_tempsense_en = !refpd_s && !bufpd_s;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            intref_en_ff <= `AOCRS_RST_REFEN;
            refbuf_en_ff <= `AOCRS_RST_REFEN;
            tempsense_en_ff <= `AOCRS_RST_REFEN;
        end else begin
            intref_en_ff <= nxt_intref_en;
            refbuf_en_ff <= nxt_refbuf_en;
            tempsense_en_ff <= nxt_tempsense_en;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence seq_reg_apply;
        acq_done && cfg_reg_active;
    endsequence

    sequence seq_pin_apply;
        acq_done && !cfg_reg_active;
    endsequence

    sequence seq_in_span;
        raw_valid && !raw_over && !raw_under;
    endsequence

    // sampled reset keeps the release edge out of the antecedent
    sequence seq_ref_all_low;
        rst_b && !refpd_s && !bufpd_s;
    endsequence

    chk_sat_high: assert property (
        raw_valid && raw_over |=> result_ff ==
            (($past(coding_ff) == AOCRS_COD_TWOS) ?
             {1'b0, {(CODE_W-1){1'b1}}} : {CODE_W{1'b1}}))
        else $error("overrange did not give the top code");

    chk_sat_low: assert property (
        raw_valid && raw_under && !raw_over |=> result_ff ==
            (($past(coding_ff) == AOCRS_COD_TWOS) ?
             {1'b1, {(CODE_W-1){1'b0}}} : {CODE_W{1'b0}}))
        else $error("underrange did not give the bottom code");

    chk_twos_msb: assert property (
        seq_in_span |=>
            result_ff[MSB-1:0] == $past(raw_code[MSB-1:0]) &&
            result_ff[MSB] == ($past(raw_code[MSB]) ^
                               ($past(coding_ff) == AOCRS_COD_TWOS)))
        else $error("result coding does not match the raw code");

    chk_valid_pulse: assert property (
        raw_valid |=> result_valid_ff ##1
            (result_valid_ff == $past(raw_valid)))
        else $error("result valid does not follow raw valid");

    chk_reg_priority: assert property (
        seq_reg_apply |=> coding_ff == ($past(cfg_coding_twos) ?
                                        AOCRS_COD_TWOS : AOCRS_COD_BINARY))
        else $error("coding not taken from the configuration register");

    chk_reg_range: assert property (
        seq_reg_apply |=> range_ff ==
            decode_range($past(cfg_bipolar), $past(cfg_span_double)))
        else $error("range not taken from the configuration register");

    chk_pin_setup: assert property (
        seq_pin_apply |=> range_ff == decode_range($past(bipolar_s),
                                                   $past(span_s)) &&
            coding_ff == ($past(coding_s) ? AOCRS_COD_BINARY :
                          AOCRS_COD_TWOS))
        else $error("pin configuration not applied");

    chk_cfg_hold: assert property (
        !acq_done |=> $stable(range_ff) && $stable(coding_ff))
        else $error("configuration changed outside an acquisition end");

    chk_ref_on: assert property (
        seq_ref_all_low |=> intref_en_ff && refbuf_en_ff && tempsense_en_ff)
        else $error("internal reference not enabled");

    chk_ref_off: assert property (
        refpd_s || bufpd_s |=> !intref_en_ff && !tempsense_en_ff &&
            (refbuf_en_ff == !$past(bufpd_s)))
        else $error("reference enabled while powered down");

endmodule

// ==== verif/aocrs_host_model.sv ====
// host side model driving the configuration and reference pins
`timescale 1ns/1ps
module aocrs_host_model (
    // clock
    input wire logic sys_clk,
    // requested pin levels from the bench, register governs flag
    input wire logic [4:0] want,
    input wire logic cfg_reg_active,
    // device pins
    output logic output_coding_select,
    output logic bipolar_select,
    output logic span_double_select,
    output logic ref_powerdown,
    output logic refbuffer_powerdown
);
    initial begin
        {refbuffer_powerdown, ref_powerdown} = 2'h0;
        {span_double_select, bipolar_select, output_coding_select} = 3'h1;
    end
    always @(posedge sys_clk) begin
        // coding and range pins frozen while the register governs
        if (!cfg_reg_active) begin
            output_coding_select <= want[0];
            bipolar_select <= want[1];
            span_double_select <= want[2];
        end
        ref_powerdown <= want[3];
        refbuffer_powerdown <= want[4];
    end
endmodule

// ==== verif/aocrs_tb.sv ====
// self-checking bench of the coding and range select block
`timescale 1ns/1ps
module tb;
    import aocrs_pkg::*;
    logic sys_clk = 0, rst_b = 0, cfg_reg_active = 0, cfg_coding_twos = 0;
    logic cfg_bipolar = 0, cfg_span_double = 0, acq_done = 0, raw_valid = 0;
    logic raw_over = 0, raw_under = 0;
    logic [15:0] raw_code = 16'h0000;
    logic [4:0] want = 5'h01;
    logic ocs, bsel, spn, pdr, pdb, rv, ie, be, te;
    logic [15:0] res;
    aocrs_coding_e cod;
    aocrs_range_e rng;
    int n_mismatch = 0, total_checks = 0, seed = 56210;
    logic [15:0] corner [6] = '{16'h0000, 16'h8000, 16'hFFFF, 16'h8001,
                               16'h7FFF, 16'h0001};
    always #2 sys_clk = ~sys_clk;
    aocrs_host_model host (.sys_clk(sys_clk), .want(want),
        .cfg_reg_active(cfg_reg_active), .output_coding_select(ocs),
        .bipolar_select(bsel), .span_double_select(spn),
        .ref_powerdown(pdr), .refbuffer_powerdown(pdb));
    aocrs_top DUT (.sys_clk(sys_clk), .rst_b(rst_b),
        .output_coding_select(ocs), .bipolar_select(bsel),
        .span_double_select(spn), .ref_powerdown(pdr),
        .refbuffer_powerdown(pdb), .cfg_reg_active(cfg_reg_active),
        .cfg_coding_twos(cfg_coding_twos), .cfg_bipolar(cfg_bipolar),
        .cfg_span_double(cfg_span_double), .acq_done(acq_done),
        .raw_valid(raw_valid), .raw_code(raw_code), .raw_over(raw_over),
        .raw_under(raw_under), .result_ff(res), .result_valid_ff(rv),
        .coding_ff(cod), .range_ff(rng), .intref_en_ff(ie),
        .refbuf_en_ff(be), .tempsense_en_ff(te));
    // saturate first, then flip only the top bit for twos complement
    function automatic logic [15:0] exp_res(input logic [15:0] c,
            input logic o, input logic u, input logic t);
        logic [15:0] b;
        b = o ? 16'hFFFF : (u ? 16'h0000 : c);
        return {b[15] ^ t, b[14:0]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
            input string msg);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg,
                got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic acq();
        @(posedge sys_clk) acq_done <= 1'b1;
        @(posedge sys_clk) acq_done <= 1'b0;
        #1;
    endtask
    // src high: register form, else pins; pins set opposite under register
    task automatic cfg_apply(input logic src, input logic tw,
            input logic bip, input logic sp);
        @(posedge sys_clk);
        cfg_reg_active <= src;
        {cfg_coding_twos, cfg_bipolar, cfg_span_double} <= {tw, bip, sp};
        want[2:0] <= src ? {~sp, ~bip, tw} : {sp, bip, ~tw};
        repeat (5) @(posedge sys_clk);
        acq();
        chk(16'(cod), 16'(tw), "coding");
        chk(16'(rng), 16'({bip, sp}), "range");
    endtask
    // tw is the coding that the last configuration asked for
    task automatic conv(input logic [15:0] c, input logic o, input logic u,
            input logic tw);
        @(posedge sys_clk);
        {raw_valid, raw_code, raw_over, raw_under} <= {1'b1, c, o, u};
        @(posedge sys_clk) raw_valid <= 1'b0;
        #1;
        chk(16'(rv), 16'h0001, "valid");
        chk(res, exp_res(c, o, u, tw), "result");
    endtask
    initial begin
        #20000;
        n_mismatch++;
        conclude();
    end
    initial begin
        @(posedge sys_clk) #1;
        chk(res, 16'h0000, "reset result");
        chk(16'(rv), 16'h0000, "reset valid");
        chk(16'({cod, rng, ie, be, te}), 16'h0000, "reset config");
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            cfg_apply(i[3], i[2], i[1], i[0]);
        end
        for (int t = 0; t < 2; t++) begin
            cfg_apply(t[0], t[0], 1'b1, 1'b0);
            foreach (corner[k]) conv(corner[k], 1'b0, 1'b0, t[0]);
            conv(16'h1234, 1'b1, 1'b0, t[0]);
            conv(16'hEDCB, 1'b0, 1'b1, t[0]);
            conv(16'h5555, 1'b1, 1'b1, t[0]);
            repeat (20) conv(16'($random(seed)), $random(seed) % 8 == 0,
                $random(seed) % 8 == 1, t[0]);
        end
        // a change without an acquisition end is held back
        cfg_apply(1'b1, 1'b0, 1'b0, 1'b1);
        @(posedge sys_clk);
        {cfg_bipolar, cfg_span_double, cfg_coding_twos} <= 3'h7;
        repeat (4) @(posedge sys_clk);
        #1;
        chk(16'(rng), 16'(AOCRS_RNG_U10), "range held");
        chk(16'(cod), 16'(AOCRS_COD_BINARY), "coding held");
        acq();
        chk(16'(rng), 16'(AOCRS_RNG_B10), "range taken");
        chk(16'(cod), 16'(AOCRS_COD_TWOS), "coding taken");
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk) want[4:3] <= i[1:0];
            repeat (6) @(posedge sys_clk);
            #1;
            chk(16'({ie, te}), (i == 0) ? 16'h0003 : 16'h0000, "ref");
            chk(16'(be), 16'(!i[1]), "buffer");
        end
        conclude();
    end
endmodule
